// ==== hw/faa_pkg.sv ====
package faa_pkg;

   // ---------------------------------------------------------------
   // Instruction word layout
   // ---------------------------------------------------------------
   localparam int          FAA_IW_W      = 14;
   localparam int          FAA_FA_W      = 7;
   localparam int          FAA_DW        = 8;
   localparam logic [1:0]  FAA_PREFIX    = 2'h0;
   localparam logic [3:0]  FAA_OPC_AND   = 4'h5;
   localparam logic [3:0]  FAA_OPC_ADD   = 4'h7;
   localparam logic        FAA_DEST_ACC  = 1'h0;
   localparam logic        FAA_DEST_FILE = 1'h1;
   localparam int          FAA_NIB_MSB   = 3;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  FAA_ACC_RST   = 8'h00;
   localparam logic        FAA_FLAG_RST  = 1'h0;
   localparam logic [6:0]  FAA_ADDR_RST  = 7'h00;
   localparam logic [7:0]  FAA_BYTE_RST  = 8'h00;

   typedef struct packed {
      logic [1:0] prefix;
      logic [3:0] opcode;
      logic       dest;
      logic [6:0] faddr;
   } faa_instr_s;

   typedef struct packed {
      logic zero;
      logic carry;
      logic digit_carry_flag;
   } faa_flags_s;

   typedef enum logic [1:0] {
      FAA_K_NONE,
      FAA_K_AND,
      FAA_K_ADD
   } faa_kind_e;

   typedef enum logic [1:0] {
      FAA_S_IDLE,
      FAA_S_READ,
      FAA_S_EXEC
   } faa_state_e;

   function automatic faa_kind_e faa_decode(input faa_instr_s iw);
      faa_decode = FAA_K_NONE;
      if (iw.prefix == FAA_PREFIX && iw.opcode == FAA_OPC_AND) begin
         faa_decode = FAA_K_AND;
      end else if (iw.prefix == FAA_PREFIX &&
                   iw.opcode == FAA_OPC_ADD) begin
         faa_decode = FAA_K_ADD;
      end
   endfunction

endpackage

// ==== hw/faa_file_alu.sv ====
// Behaviour
// - Recognise AND form: 00, 0101, destination bit, seven-bit file address.
// - Recognise add form: 00, 0111, destination bit, seven-bit file address.
// - File address is seven bits, registers 0 to 127 of current bank.
// - AND: result is accumulator AND file; only zero flag changes.
// - Add: eight-bit sum; carry, digit carry and zero flags change.
// - Destination 0 writes accumulator; 1 overwrites the file register.
`timescale 1ns/1ps

module faa_file_alu
   import faa_pkg::*;
(
   input  wire logic              ref_clk,        // Core clock, 10 MHz
   input  wire logic              sys_rst,        // Sync reset, high
   input  wire logic              instr_valid,    // Instruction offered
   input  wire faa_instr_s        instr_word,     // 14-bit opcode word
   input  wire logic              accum_ld,       // Preload accumulator
   input  wire logic [7:0]        accum_ld_data,  // Preload value
   input  wire logic [7:0]        file_rd_data,   // File data, 1 cyc late
   output logic                   instr_ready_r,  // Can take a word
   output logic                   file_rd_en_r,   // File read strobe
   output logic [6:0]             file_rd_addr_r, // File read address
   output logic                   file_wr_en_r,   // File write strobe
   output logic [6:0]             file_wr_addr_r, // File write address
   output logic [7:0]             file_wr_data_r, // File write data
   output logic [7:0]             accum_r,        // Accumulator
   output faa_flags_s             flags_r,        // Status flags
   output logic [7:0]             result_r,       // Last result
   output logic                   done_r,         // Execute finished
   output logic                   unknown_r       // Word not handled
);

   // ---------------------------------------------------------------
   // Decode and sequencing
   // ---------------------------------------------------------------
   faa_state_e  state_r;
   faa_kind_e   kind_r;
   logic        dest_r;
   logic [6:0]  faddr_r;
   faa_kind_e   kind_in;
   logic        take;

   assign kind_in = faa_decode(instr_word);
   assign take    = instr_valid && instr_ready_r;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_r <= FAA_S_IDLE;
      end else begin
         unique case (state_r)
            FAA_S_IDLE: begin
               if (take && kind_in != FAA_K_NONE) begin
                  state_r <= FAA_S_READ;
               end
            end
            FAA_S_READ: begin
               state_r <= FAA_S_EXEC;
            end
            FAA_S_EXEC: begin
               state_r <= FAA_S_IDLE;
            end
         endcase
      end
   end

   // Ready drops for the read and execute cycles; other words keep it up
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         instr_ready_r <= 1'b0;
      end else begin
         instr_ready_r <= (state_r == FAA_S_IDLE && !take) ||
                          (state_r == FAA_S_IDLE && take &&
                           kind_in == FAA_K_NONE) ||
                          state_r == FAA_S_EXEC;
      end
   end

   // Operand capture; only the two handled forms start a read
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         kind_r         <= FAA_K_NONE;
         dest_r         <= FAA_DEST_ACC;
         faddr_r        <= FAA_ADDR_RST;
         file_rd_en_r   <= 1'b0;
         file_rd_addr_r <= FAA_ADDR_RST;
         unknown_r      <= 1'b0;
      end else begin
         file_rd_en_r <= 1'b0;
         unknown_r    <= take && kind_in == FAA_K_NONE;
         if (take && kind_in != FAA_K_NONE) begin
            kind_r         <= kind_in;
            dest_r         <= instr_word.dest;
            faddr_r        <= instr_word.faddr;
            file_rd_en_r   <= 1'b1;
            file_rd_addr_r <= instr_word.faddr;
         end
      end
   end

   // ---------------------------------------------------------------
   // Datapath
   // ---------------------------------------------------------------
   logic [8:0]  sum9;
   logic [4:0]  nib5;
   logic [7:0]  res;
   logic        exec;

   assign exec = state_r == FAA_S_EXEC;
   assign sum9 = {1'b0, accum_r} + {1'b0, file_rd_data};
   // Digit carry comes from its own sum of the low nibbles
   assign nib5 = {1'b0, accum_r[FAA_NIB_MSB:0]} +
                 {1'b0, file_rd_data[FAA_NIB_MSB:0]};
   assign res  = (kind_r == FAA_K_AND) ? (accum_r & file_rd_data)
                                       : sum9[7:0];

   // External preload yields to an executing instruction that writes the accumulator
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         accum_r <= FAA_ACC_RST;
      end else if (exec && dest_r == FAA_DEST_ACC) begin
         accum_r <= res;
      end else if (accum_ld) begin
         accum_r <= accum_ld_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         file_wr_en_r   <= 1'b0;
         file_wr_addr_r <= FAA_ADDR_RST;
         file_wr_data_r <= FAA_BYTE_RST;
      end else begin
         file_wr_en_r <= exec && dest_r == FAA_DEST_FILE;
         if (exec) begin
            file_wr_addr_r <= faddr_r;
            file_wr_data_r <= res;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         flags_r <= '{FAA_FLAG_RST, FAA_FLAG_RST, FAA_FLAG_RST};
      end else if (exec) begin
         flags_r.zero <= res == 8'h00;
         if (kind_r == FAA_K_ADD) begin
            flags_r.carry            <= sum9[8];
            flags_r.digit_carry_flag <= nib5[4];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         result_r <= FAA_BYTE_RST;
         done_r   <= 1'b0;
      end else begin
         done_r <= exec;
         if (exec) begin
            result_r <= res;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [7:0] chk_a_r;
   logic [7:0] chk_f_r;
   logic       chk_ld_r;

   // Operands seen at execute, kept for the result checks
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         chk_a_r  <= 8'h00;
         chk_f_r  <= 8'h00;
         chk_ld_r <= 1'b0;
      end else begin
         chk_ld_r <= accum_ld;
         if (exec) begin
            chk_a_r <= accum_r;
            chk_f_r <= file_rd_data;
         end
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   property p_and_decode;
      take && instr_word.prefix == 2'h0 && instr_word.opcode == 4'h5
      |=> file_rd_en_r && kind_r == FAA_K_AND ##2 done_r;
   endproperty
   a_and_decode: assert property (p_and_decode)
      else $error("AND form not started or not finished");

   property p_add_decode;
      take && instr_word.prefix == 2'h0 && instr_word.opcode == 4'h7
      |=> file_rd_en_r && kind_r == FAA_K_ADD ##2 done_r;
   endproperty
   a_add_decode: assert property (p_add_decode)
      else $error("Add form not started or not finished");

   property p_faddr;
      take && kind_in != FAA_K_NONE
      |=> file_rd_addr_r == $past(instr_word.faddr)
          ##2 (!file_wr_en_r || file_wr_addr_r == $past(faddr_r, 2));
   endproperty
   a_faddr: assert property (p_faddr)
      else $error("File address not carried through");

   property p_and_result;
      done_r && kind_r == FAA_K_AND
      |-> result_r == (chk_a_r & chk_f_r) && $stable(flags_r.carry)
          && $stable(flags_r.digit_carry_flag);
   endproperty
   a_and_result: assert property (p_and_result)
      else $error("AND result or flags wrong");

   property p_add_result;
      done_r && kind_r == FAA_K_ADD
      |-> {flags_r.carry, result_r} == {1'b0, chk_a_r} + {1'b0, chk_f_r};
   endproperty
   a_add_result: assert property (p_add_result)
      else $error("Add sum or carry wrong");

   property p_dest;
      done_r |-> (dest_r ? (file_wr_en_r && file_wr_data_r == result_r
                            && (chk_ld_r || $stable(accum_r)))
                         : (!file_wr_en_r && accum_r == result_r));
   endproperty
   a_dest: assert property (p_dest)
      else $error("Result sent to wrong destination");

   property p_flags;
      done_r |-> flags_r.zero == (result_r == 8'h00) &&
         (kind_r != FAA_K_ADD || flags_r.digit_carry_flag ==
          ((chk_a_r[3:0] + chk_f_r[3:0]) > 8'h0f));
   endproperty
   a_flags: assert property (p_flags)
      else $error("Zero or digit carry wrong");

   // ---------------------------------------------------------------
   // Sequencing and hold checks
   // ---------------------------------------------------------------
   // Busy window is two cycles; a word offered then is not taken
   property p_ready_busy;
      take && kind_in != FAA_K_NONE
      |=> !instr_ready_r ##1 !instr_ready_r ##1 instr_ready_r;
   endproperty
   a_ready_busy: assert property (p_ready_busy)
      else $error("Ready not low for the two busy cycles");

   // Raw fields here, so a fault in the shared decoder still shows
   property p_unknown;
      take && !(instr_word.prefix == 2'h0 &&
                instr_word.opcode inside {4'h5, 4'h7})
      |=> unknown_r && !file_rd_en_r && instr_ready_r;
   endproperty
   a_unknown: assert property (p_unknown)
      else $error("Other word started a file access");

   property p_rd_strobe;
      file_rd_en_r
      |-> file_rd_addr_r == faddr_r && state_r == FAA_S_READ
          ##1 !file_rd_en_r;
   endproperty
   a_rd_strobe: assert property (p_rd_strobe)
      else $error("File read strobe or address out of step");

   // Flags move only with a finished instruction
   property p_flags_hold;
      $changed(flags_r) && !$past(sys_rst) |-> done_r;
   endproperty
   a_flags_hold: assert property (p_flags_hold)
      else $error("Flags changed without an instruction");

   property p_acc_hold;
      $changed(accum_r) && !$past(sys_rst)
      |-> (done_r && dest_r == FAA_DEST_ACC) || $past(accum_ld);
   endproperty
   a_acc_hold: assert property (p_acc_hold)
      else $error("Accumulator changed without a cause");

   property p_wr_dest;
      file_wr_en_r |-> done_r && dest_r == FAA_DEST_FILE;
   endproperty
   a_wr_dest: assert property (p_wr_dest)
      else $error("File written without a file destination");

   property p_done_pulse;
      done_r |=> !done_r && !file_wr_en_r;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("Done or file write held too long");

   // Zero from the operands, not from the result register
   property p_and_zero;
      done_r && kind_r == FAA_K_AND
      |-> flags_r.zero == ((chk_a_r & chk_f_r) == 8'h00);
   endproperty
   a_and_zero: assert property (p_and_zero)
      else $error("AND zero flag wrong");

   c_and_acc: cover property (done_r && kind_r == FAA_K_AND && !dest_r);
   c_and_file: cover property (done_r && kind_r == FAA_K_AND && dest_r);
   c_add_file: cover property (done_r && kind_r == FAA_K_ADD && dest_r
                               && flags_r.carry);
   c_zero: cover property (done_r && flags_r.zero);
   c_unknown: cover property (unknown_r);

endmodule

// ==== verification/faa_regfile_model.sv ====
`timescale 1ns/1ps

module faa_regfile_model (
   input  wire logic       ref_clk,  // Core clock
   input  wire logic       rd_en,    // Read strobe
   input  wire logic [6:0] rd_addr,  // Read address
   input  wire logic       wr_en,    // Write strobe
   input  wire logic [6:0] wr_addr,  // Write address
   input  wire logic [7:0] wr_data,  // Write data
   output logic      [7:0] rd_data   // Data, cycle after strobe
);
   // ---------------------------------------------------------------
   // Storage, loaded by the bench at time zero
   // ---------------------------------------------------------------
   logic [7:0] mem [128];
   initial rd_data = 8'h00;
   // Outside its valid cycle the bus toggles, so stale data never matches
   always @(posedge ref_clk) begin
      rd_data <= rd_en ? mem[rd_addr] : ~rd_data;
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end
endmodule

// ==== verification/file_and_add_with_accumulator_tb.sv ====
`timescale 1ns/1ps

module file_and_add_with_accumulator_tb import faa_pkg::*;;
   typedef struct {
      logic hit; logic [7:0] res; faa_flags_s fl;
      logic [7:0] acc; logic dst; logic [6:0] fa;
   } faa_note_s;
   logic ref_clk = 0, sys_rst = 1, instr_valid = 0, accum_ld = 0;
   faa_instr_s instr_word = '0;
   logic [7:0] accum_ld_data = 8'h00, file_rd_data;
   logic instr_ready_r, file_rd_en_r, file_wr_en_r, done_r, unknown_r;
   logic [6:0] file_rd_addr_r, file_wr_addr_r;
   logic [7:0] file_wr_data_r, accum_r, result_r, acc_s;
   faa_flags_s flags_r, fl_s;
   logic [7:0] mem_s [128];
   faa_note_s q[$], mon_n;
   int mismatches = 0, total_checks = 0, cyc = 0;

   always #50 ref_clk = ~ref_clk;

   faa_file_alu uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .instr_valid(instr_valid), .instr_word(instr_word),
      .accum_ld(accum_ld), .accum_ld_data(accum_ld_data),
      .file_rd_data(file_rd_data), .instr_ready_r(instr_ready_r),
      .file_rd_en_r(file_rd_en_r), .file_rd_addr_r(file_rd_addr_r),
      .file_wr_en_r(file_wr_en_r), .file_wr_addr_r(file_wr_addr_r),
      .file_wr_data_r(file_wr_data_r), .accum_r(accum_r),
      .flags_r(flags_r), .result_r(result_r), .done_r(done_r),
      .unknown_r(unknown_r));
   faa_regfile_model rfm (.ref_clk(ref_clk), .rd_en(file_rd_en_r),
      .rd_addr(file_rd_addr_r), .wr_en(file_wr_en_r),
      .wr_addr(file_wr_addr_r), .wr_data(file_wr_data_r),
      .rd_data(file_rd_data));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      check(8'(q.size()), 8'h00);
      if (mismatches == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wait_ready;
      @(negedge ref_clk);
      while (instr_ready_r !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
   endtask

   task automatic preload(input logic [7:0] v);
      wait_ready();
      accum_ld <= 1'b1;
      accum_ld_data <= v;
      @(posedge ref_clk);
      accum_ld <= 1'b0;
      acc_s = v;
   endtask

   // Expectation is noted before the word goes out
   task automatic issue(input faa_instr_s w);
      faa_note_s n;
      logic [8:0] s;
      n = '{default: '0};
      n.hit = w.prefix == 2'h0 && w.opcode inside {4'h5, 4'h7};
      n.fa = w.faddr;
      n.dst = w.dest;
      if (n.hit) begin
         if (w.opcode == 4'h5) begin
            n.res = acc_s & mem_s[w.faddr];
         end else begin
            s = {1'b0, acc_s} + {1'b0, mem_s[w.faddr]};
            n.res = s[7:0];
            fl_s.carry = s[8];
            fl_s.digit_carry_flag =
               ({1'b0, acc_s[3:0]} + {1'b0, mem_s[w.faddr][3:0]}) > 5'hf;
         end
         fl_s.zero = n.res == 8'h00;
         if (w.dest) mem_s[w.faddr] = n.res;
         else acc_s = n.res;
      end
      n.fl = fl_s;
      n.acc = acc_s;
      q.push_back(n);
      wait_ready();
      instr_valid <= 1'b1;
      instr_word <= w;
      @(posedge ref_clk);
      instr_valid <= 1'b0;
   endtask

   // ---------------------------------------------------------------
   // Result watcher and run
   // ---------------------------------------------------------------
   always @(negedge ref_clk) begin
      if (done_r === 1'b1 || unknown_r === 1'b1) begin
         mon_n = q.pop_front();
         check(8'(unknown_r), 8'(!mon_n.hit));
         check(8'(instr_ready_r), 8'h01);
         if (mon_n.hit) begin
            check(8'(file_rd_addr_r), 8'(mon_n.fa));
            check(result_r, mon_n.res);
            check(8'(flags_r), 8'(mon_n.fl));
            check(accum_r, mon_n.acc);
            check(8'(file_wr_en_r), 8'(mon_n.dst));
            if (mon_n.dst) begin
               check(8'(file_wr_addr_r), 8'(mon_n.fa));
               check(file_wr_data_r, mon_n.res);
            end
         end
      end
   end

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         stop_test();
      end
   end

   initial begin
      faa_instr_s w;
      void'($urandom(54578));
      for (int i = 0; i < 128; i++) mem_s[i] = 8'($urandom);
      mem_s[127] = 8'h01;
      for (int i = 0; i < 128; i++) rfm.mem[i] = mem_s[i];
      acc_s = 8'h00;
      fl_s = '0;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(negedge ref_clk);
      check(accum_r, 8'h00);
      check(8'(flags_r), 8'h00);
      // Boundary address, all three flags set, then AND keeps carry
      preload(8'hff);
      issue('{2'h0, 4'h7, 1'h1, 7'h7f});
      issue('{2'h0, 4'h5, 1'h0, 7'h7f});
      issue('{2'h0, 4'h7, 1'h0, 7'h00});
      for (int i = 0; i < 60; i++) begin
         if (i % 3 == 0) preload(8'($urandom));
         w.prefix = 2'h0;
         w.opcode = $urandom_range(1) ? 4'h7 : 4'h5;
         w.dest = 1'($urandom);
         w.faddr = 7'($urandom);
         issue(w);
      end
      for (int j = 0; j < 16; j++) begin
         issue('{2'(j % 4), 4'(j), 1'($urandom), 7'($urandom)});
      end
      repeat (6) @(posedge ref_clk);
      stop_test();
   end
endmodule
